/* pkg/dps_pkg.sv */
// Package: register map, field positions and timing constants
package dps_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_TIMING_CTRL = 8'h02;
  localparam logic [7:0] ADDR_MCS_CTRL = 8'h03;
  localparam int TIMING_CTRL_W = 16;
  localparam int MCS_CTRL_W = 32;
  localparam logic [15:0] TIMING_CTRL_RST = 16'h0000;
  localparam logic [31:0] MCS_CTRL_RST = 32'h0000_0000;
  // Timing control fields
  localparam int F_CLK_DLY_HI = 15;
  localparam int F_CLK_DLY_LO = 11;
  localparam int F_MARGIN_HI = 10;
  localparam int F_MARGIN_LO = 7;
  localparam int F_LVDS_CLK = 6;
  localparam int F_CLK_INV = 5;
  localparam int F_DLY_EN = 4;
  localparam int F_AUTO_MODE = 3;
  localparam int F_SET_HIGH = 2;
  localparam int F_DCI_RISE = 1;
  localparam int F_RESERVED = 0;
  // Multichip fields
  localparam int F_CORR_HI = 31;
  localparam int F_CORR_LO = 27;
  localparam int F_SYNC_RX_EN = 26;
  localparam int F_SYNC_TX_EN = 25;
  localparam int F_SLAVE = 16;
  // Interpolation codes that allow slave mode
  localparam logic [1:0] INTERP_4X = 2'h2;
  localparam logic [1:0] INTERP_8X = 2'h3;
  // Delay figures, in picoseconds
  localparam int CLK_DLY_MIN_PS = 700;
  localparam int CLK_DLY_MAX_PS = 6500;
  localparam int DLY_STEP_PS = 190;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int DLY_TAPS = (CLK_DLY_MAX_PS + CLK_PERIOD_PS - 1)
                            / CLK_PERIOD_PS + 1;
  localparam int TAP_W = $clog2(DLY_TAPS);
  localparam int SAMP_HALF = 2;
endpackage

/* logic/dps_sync_edge.sv */
// Two-stage synchroniser with edge detection
`timescale 1ns/100ps
module dps_sync_edge #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out,
  output logic [WIDTH-1:0] fall_out
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_stable;
  logic [WIDTH-1:0] next_prev;

  always_comb begin
    next_meta = meta;
    next_stable = stable;
    next_prev = prev;
    if (ce_in) begin
      next_meta = async_in;
      next_stable = meta;
      next_prev = stable;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
    end
  end

  assign level_out = stable;
  assign rise_out = stable & ~prev;
  assign fall_out = ~stable & prev;
endmodule // dps_sync_edge

/* logic/dps_tap_delay.sv */
// Tapped delay line for the output data clock
`timescale 1ns/100ps
module dps_tap_delay #(
  parameter int DEPTH = 4,
  parameter int SEL_W = 2
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic sig_in,
  input wire logic [SEL_W-1:0] tap_in,
  output logic sig_out
);
  logic [DEPTH-1:0] line;
  logic [DEPTH-1:0] next_line;

  always_comb begin
    next_line = line;
    if (ce_in) begin
      next_line = {line[DEPTH-2:0], sig_in};
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      line <= '0;
    end else begin
      line <= next_line;
    end
  end

  // Tap 0 is one register stage behind the input
  assign sig_out = line[tap_in];
endmodule // dps_tap_delay

/* logic/dps_port_timing.sv */
// Data port timing and multichip sync enable register bank
`timescale 1ns/100ps
module dps_port_timing #(
  parameter int DATA_W = 16,
  parameter int HALF_PERIOD = dps_pkg::SAMP_HALF
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [1:0] interp_factor_in,
  input wire logic mcs_sync_pulse_in,
  input wire logic external_data_clock_input_in,
  input wire logic [DATA_W-1:0] port_data_in,
  output logic output_data_clock_out,
  output logic lvds_sync_out,
  output logic [DATA_W-1:0] sampled_data_out,
  output logic sample_valid_out,
  output logic slave_active_out,
  output logic setup_hold_err_out,
  output logic [4:0] correlate_threshold_out,
  output logic sync_rx_enable_out,
  output logic sync_tx_enable_out
);
  localparam int TW = dps_pkg::TAP_W;

  // Delay code to whole-cycle tap, rounded down, never below one cycle
  function automatic logic [TW-1:0] clk_tap(input logic [4:0] code);
    int ps;
    int cyc;
    ps = dps_pkg::CLK_DLY_MIN_PS + dps_pkg::DLY_STEP_PS * int'(code);
    cyc = ps / dps_pkg::CLK_PERIOD_PS;
    if (cyc < 1) cyc = 1;
    return TW'(cyc - 1);
  endfunction

  // Margin code to check window in cycles, rounded up
  function automatic logic [3:0] margin_cycles(input logic [3:0] code);
    int ps;
    ps = dps_pkg::DLY_STEP_PS * int'(code);
    return 4'((ps + dps_pkg::CLK_PERIOD_PS - 1) / dps_pkg::CLK_PERIOD_PS);
  endfunction

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [15:0] timing_ctrl;
  logic [31:0] mcs_ctrl;
  logic [31:0] rdata;
  logic [15:0] next_timing_ctrl;
  logic [31:0] next_mcs_ctrl;
  logic [31:0] next_rdata;
  logic hit_timing;
  logic hit_mcs;

  assign hit_timing = reg_addr_in == dps_pkg::ADDR_TIMING_CTRL;
  assign hit_mcs = reg_addr_in == dps_pkg::ADDR_MCS_CTRL;

  always_comb begin
    next_timing_ctrl = timing_ctrl;
    next_mcs_ctrl = mcs_ctrl;
    next_rdata = rdata;
    if (ce_in) begin
      if (reg_wr_in && hit_timing) begin
        // Bit 2 is stored as written; software keeps it high
        next_timing_ctrl = reg_wdata_in[15:0];
      end
      if (reg_wr_in && hit_mcs) begin
        next_mcs_ctrl = reg_wdata_in;
      end
      if (reg_rd_in) begin
        if (hit_timing) begin
          next_rdata = {16'h0000, timing_ctrl};
        end else if (hit_mcs) begin
          next_rdata = mcs_ctrl;
        end else begin
          next_rdata = 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      timing_ctrl <= dps_pkg::TIMING_CTRL_RST;
      mcs_ctrl <= dps_pkg::MCS_CTRL_RST;
      rdata <= 32'h0000_0000;
    end else begin
      timing_ctrl <= next_timing_ctrl;
      mcs_ctrl <= next_mcs_ctrl;
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_out = rdata;

  // Field views; bit 0 and bit 2 drive nothing
  logic [4:0] dly_code;
  logic [3:0] margin_code;
  logic lvds_clk_sel;
  logic clk_inv;
  logic dly_en;
  logic auto_mode;
  logic dci_rise_sel;
  logic slave_req;
  logic slave;
  assign dly_code = timing_ctrl[dps_pkg::F_CLK_DLY_HI:dps_pkg::F_CLK_DLY_LO];
  assign margin_code = timing_ctrl[dps_pkg::F_MARGIN_HI:dps_pkg::F_MARGIN_LO];
  assign lvds_clk_sel = timing_ctrl[dps_pkg::F_LVDS_CLK];
  assign clk_inv = timing_ctrl[dps_pkg::F_CLK_INV];
  assign dly_en = timing_ctrl[dps_pkg::F_DLY_EN];
  assign auto_mode = timing_ctrl[dps_pkg::F_AUTO_MODE];
  assign dci_rise_sel = timing_ctrl[dps_pkg::F_DCI_RISE];
  assign slave_req = mcs_ctrl[dps_pkg::F_SLAVE];
  // Slave request is ignored at 1x and 2x rates
  assign slave = slave_req && (interp_factor_in == dps_pkg::INTERP_4X ||
                 interp_factor_in == dps_pkg::INTERP_8X);
  assign correlate_threshold_out =
    mcs_ctrl[dps_pkg::F_CORR_HI:dps_pkg::F_CORR_LO];
  assign sync_rx_enable_out = mcs_ctrl[dps_pkg::F_SYNC_RX_EN];
  assign sync_tx_enable_out = mcs_ctrl[dps_pkg::F_SYNC_TX_EN];
  assign slave_active_out = slave;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [DATA_W:0] pin_level;
  logic [DATA_W:0] pin_rise;
  logic [DATA_W:0] pin_fall;

  dps_sync_edge #(.WIDTH(DATA_W + 1)) u_pin_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .async_in({external_data_clock_input_in, port_data_in}),
    .level_out(pin_level),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  // ---------------------------------------------------------------
  // Internal sampling clock, output clock and sampling
  // ---------------------------------------------------------------
  logic [7:0] div_cnt;
  logic samp_clk;
  logic [3:0] quiet_cnt;
  logic [TW-1:0] auto_tap;
  logic [DATA_W-1:0] sampled;
  logic valid;
  logic err;
  logic [7:0] next_div_cnt;
  logic next_samp_clk;
  logic [3:0] next_quiet_cnt;
  logic [TW-1:0] next_auto_tap;
  logic [DATA_W-1:0] next_sampled;
  logic next_valid;
  logic next_err;
  logic samp_edge;
  logic data_moved;
  logic base_clk;
  logic dly_clk;
  logic [TW-1:0] tap_sel;

  assign data_moved = |(pin_rise[DATA_W-1:0] | pin_fall[DATA_W-1:0]);
  // Slave samples on the chosen edge of the external clock
  assign samp_edge = slave
    ? (dci_rise_sel ? pin_rise[DATA_W] : pin_fall[DATA_W])
    : (next_samp_clk && !samp_clk);

  always_comb begin
    next_div_cnt = div_cnt;
    next_samp_clk = samp_clk;
    next_quiet_cnt = quiet_cnt;
    next_auto_tap = auto_tap;
    next_sampled = sampled;
    next_valid = 1'b0;
    next_err = err;
    if (ce_in) begin
      if (div_cnt == 8'(HALF_PERIOD - 1)) begin
        next_div_cnt = 8'h00;
        next_samp_clk = !samp_clk;
      end else begin
        next_div_cnt = div_cnt + 8'h01;
      end
      next_quiet_cnt = data_moved ? 4'h0
        : (quiet_cnt == 4'hf ? quiet_cnt : quiet_cnt + 4'h1);
      if (samp_edge) begin
        next_sampled = pin_level[DATA_W-1:0];
        next_valid = 1'b1;
        // Window checks only while the delay enable bit is set
        next_err = dly_en && (data_moved ||
                   quiet_cnt < margin_cycles(margin_code));
        if (auto_mode && dly_en && next_err) begin
          next_auto_tap = auto_tap + TW'(1);
        end
      end
      if (!auto_mode) begin
        next_auto_tap = clk_tap(dly_code);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      div_cnt <= 8'h00;
      samp_clk <= 1'b0;
      quiet_cnt <= 4'h0;
      auto_tap <= '0;
      sampled <= '0;
      valid <= 1'b0;
      err <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      samp_clk <= next_samp_clk;
      quiet_cnt <= next_quiet_cnt;
      auto_tap <= next_auto_tap;
      sampled <= next_sampled;
      valid <= next_valid;
      err <= next_err;
    end
  end

  assign base_clk = samp_clk ^ clk_inv;
  assign tap_sel = auto_mode ? auto_tap : clk_tap(dly_code);

  dps_tap_delay #(.DEPTH(dps_pkg::DLY_TAPS), .SEL_W(TW)) u_clk_dly (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .sig_in(base_clk),
    .tap_in(tap_sel),
    .sig_out(dly_clk)
  );

  // Delay cell bypassed unless enabled
  assign output_data_clock_out = dly_en ? dly_clk : base_clk;
  assign lvds_sync_out = lvds_clk_sel ? output_data_clock_out
                                      : mcs_sync_pulse_in;
  assign sampled_data_out = sampled;
  assign sample_valid_out = valid;
  assign setup_hold_err_out = err;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_write_timing;
    ce_in && reg_wr_in && reg_addr_in == dps_pkg::ADDR_TIMING_CTRL;
  endsequence
  sequence s_read_timing;
    ce_in && reg_rd_in && reg_addr_in == dps_pkg::ADDR_TIMING_CTRL
    && !reg_wr_in;
  endsequence

  chk_timing_wr_rd: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    s_write_timing ##1 s_read_timing |=>
      reg_rdata_out == {16'h0000, $past(reg_wdata_in[15:0], 2)})
    else $error("timing register readback mismatch");
  chk_mcs_wr_rd: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    ce_in && reg_wr_in && hit_mcs ##1 ce_in && reg_rd_in && hit_mcs
      && !reg_wr_in |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("multichip register readback mismatch");
  chk_lvds_route: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    lvds_sync_out == (timing_ctrl[dps_pkg::F_LVDS_CLK]
      ? output_data_clock_out : mcs_sync_pulse_in))
    else $error("lvds pad source wrong");
  chk_clk_bypass: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    !timing_ctrl[dps_pkg::F_DLY_EN] |->
      output_data_clock_out == (samp_clk ^ timing_ctrl[dps_pkg::F_CLK_INV]))
    else $error("output clock phase wrong");
  chk_no_err_idle: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    ce_in && !timing_ctrl[dps_pkg::F_DLY_EN] && samp_edge
      |=> !setup_hold_err_out)
    else $error("window check active while disabled");
  chk_slave_rate: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    slave_active_out |-> interp_factor_in[1])
    else $error("slave mode at low rate");
  chk_slave_edge: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    ce_in && slave && !dci_rise_sel && pin_fall[DATA_W]
      |=> sample_valid_out && sampled_data_out == $past(pin_level[DATA_W-1:0]))
    else $error("slave falling edge not sampled");
  chk_sync_enables: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    ce_in && reg_wr_in && hit_mcs |=>
      sync_rx_enable_out == $past(reg_wdata_in[dps_pkg::F_SYNC_RX_EN]) &&
      sync_tx_enable_out == $past(reg_wdata_in[dps_pkg::F_SYNC_TX_EN]))
    else $error("sync enables not updated");
  chk_manual_tap: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    !auto_mode |-> tap_sel == clk_tap(dly_code))
    else $error("manual delay tap wrong");
  chk_reset_zero: assert property (@(posedge clk_in)
    $past(sys_rst_in) |-> timing_ctrl == 16'h0000 && mcs_ctrl == 32'h0)
    else $error("registers not zero after reset");
endmodule // dps_port_timing

/* dv/dps_src_model.sv */
// Data source model driving the external data clock and data port
`timescale 1ns/100ps
module dps_src_model (
  input wire logic run_in,
  input wire logic rise_in,
  input wire logic skew_in,
  output logic dclk_out,
  output logic [15:0] data_out
);
  // ----------------------------------------------------------------
  // Frame generator
  // ----------------------------------------------------------------
  // Clock stands still low between frames; only whole periods are sent
  initial begin
    dclk_out = 1'b0;
    data_out = 16'h1234;
    forever begin
      wait (run_in);
      #78;
      // Late move lands inside the check window on purpose
      if (skew_in) data_out = {data_out[14:0], ~data_out[15]};
      #2;
      dclk_out = 1'b1;
      // Data moves on the edge away from the sampling edge
      if (!rise_in) data_out = {data_out[14:0], ~data_out[15]};
      #80;
      dclk_out = 1'b0;
      if (rise_in && !skew_in) data_out = {data_out[14:0], ~data_out[15]};
    end
  end
endmodule // dps_src_model

/* dv/dps_port_timing_tb.sv */
// Self-checking bench for the data port timing register bank
`timescale 1ns/100ps
module dps_port_timing_tb;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic [1:0] interp_factor_in = 2'h0;
  logic mcs_sync_pulse_in = 1'b0;
  logic run = 1'b0;
  logic rise = 1'b0;
  logic skew = 1'b0;
  logic dclk;
  logic [15:0] pdata;
  logic [31:0] reg_rdata_out;
  logic odc, lvds, valid, slave, sh_err, rx_en, tx_en;
  logic [15:0] sdata;
  logic [4:0] thr;
  int n_errors = 0;
  int n_checks = 0;
  realtime t_rise = 0.0;
  realtime t_fall = 0.0;
  localparam logic [7:0] A2 = dps_pkg::ADDR_TIMING_CTRL;
  localparam logic [7:0] A3 = dps_pkg::ADDR_MCS_CTRL;

  always #2 clk_in = ~clk_in;
  always @(posedge dclk) t_rise = $realtime;
  always @(negedge dclk) t_fall = $realtime;

  dps_port_timing #(.DATA_W(16), .HALF_PERIOD(dps_pkg::SAMP_HALF)) i_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .interp_factor_in(interp_factor_in),
    .mcs_sync_pulse_in(mcs_sync_pulse_in),
    .external_data_clock_input_in(dclk), .port_data_in(pdata),
    .output_data_clock_out(odc), .lvds_sync_out(lvds),
    .sampled_data_out(sdata), .sample_valid_out(valid),
    .slave_active_out(slave), .setup_hold_err_out(sh_err),
    .correlate_threshold_out(thr), .sync_rx_enable_out(rx_en),
    .sync_tx_enable_out(tx_en));

  dps_src_model i_src (.run_in(run), .rise_in(rise), .skew_in(skew),
    .dclk_out(dclk), .data_out(pdata));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    chk("register read", exp, reg_rdata_out);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    wr(A2, 32'hffff_ffff);
    wr(A3, 32'hffff_ffff);
    sys_rst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    sys_rst_in = 1'b0;
    rdchk(A2, dps_pkg::TIMING_CTRL_RST);
    rdchk(A3, dps_pkg::MCS_CTRL_RST);
    chk("reset outputs", 0, {thr, rx_en, tx_en});
    $display("test reset done");
  endtask

  task automatic t_rw();
    logic [31:0] pat [4] = '{32'hffff_ffff, 32'h0000_0004,
                             32'h1234_a5a6, 32'h5a5a_5a5c};
    foreach (pat[i]) begin
      wr(A2, pat[i]);
      rdchk(A2, {16'h0, pat[i][15:0]});
      wr(A3, pat[i]);
      rdchk(A3, pat[i]);
      chk("threshold", pat[i][31:27], thr);
      chk("rx enable", pat[i][26], rx_en);
      chk("tx enable", pat[i][25], tx_en);
    end
    wr(A3, 32'h0);
    $display("test read back done");
  endtask

  task automatic t_unmapped();
    wr(8'h04, 32'hffff_ffff);
    rdchk(8'h04, 32'h0);
    wr(A2, 32'h0000_0004);
    ce_in = 1'b0;
    wr(A2, 32'h0000_fffc);
    ce_in = 1'b1;
    rdchk(A2, 32'h0000_0004);
    $display("test unmapped done");
  endtask

  task automatic t_routing();
    int seen;
    interp_factor_in = 2'h0;
    for (int i = 0; i < 4; i++) begin
      wr(A2, {25'h0, i[0], i[0], i[1], 4'h4});
      seen = 0;
      repeat (40) begin
        @(negedge clk_in);
        if (i[0]) chk("lvds from clock", odc, lvds);
        else chk("lvds from sync", mcs_sync_pulse_in, lvds);
        if (valid === 1'b1) begin
          seen++;
          if (!i[1]) chk("clock phase", !i[0], odc);
        end
        mcs_sync_pulse_in = ~mcs_sync_pulse_in;
      end
      chk("master samples", 40 / (2 * dps_pkg::SAMP_HALF), seen);
    end
    $display("test clock routing done");
  endtask

  task automatic t_slave(input logic [1:0] f, input logic r, input int n,
                         input logic [3:0] m);
    int seen;
    seen = 0;
    interp_factor_in = f;
    rise = r;
    wr(A2, {21'h0, m, 2'h0, m != 0, 2'h1, r, 1'b0});
    wr(A3, 32'h0001_0000);
    repeat (8) @(negedge clk_in);
    run = 1'b1;
    repeat (330) begin
      @(negedge clk_in);
      if (valid === 1'b1) begin
        seen++;
        chk("slave active", f[1], slave);
        if (f[1] && !skew) chk("slave data", pdata, sdata);
        if (f[1]) chk("edge", 1, r ? t_rise > t_fall : t_fall > t_rise);
      end
    end
    run = 1'b0;
    chk("sample count", n, seen);
    if (skew) chk("setup hold error", m != 0, sh_err);
    repeat (50) @(negedge clk_in);
    $display("test slave done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk_in);
    sys_rst_in = 1'b0;
    t_reset();
    t_rw();
    t_unmapped();
    t_routing();
    for (int k = 0; k < 4; k++) t_slave(2'h2 + k[1], k[0], 8, 4'h0);
    // Slave bit with 1x interpolation stays on master sampling
    t_slave(2'h0, 1'b1, 330 / (2 * dps_pkg::SAMP_HALF), 4'h0);
    skew = 1'b1;
    t_slave(2'h2, 1'b1, 8, 4'h0);
    t_slave(2'h2, 1'b1, 8, 4'hf);
    skew = 1'b0;
    end_of_test();
  end

  // Whole run needs about 12 us; five times that is a hang
  initial begin
    #60000;
    n_errors++;
    end_of_test();
  end
endmodule // dps_port_timing_tb
